// File: rtr_pkg.sv
// constants and types for the three-tone ringer sequencer
`default_nettype none
package rtr_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int MAIN_HZ = 455_000;
    localparam int MAIN_DIV = (CLK_HZ + MAIN_HZ / 2) / MAIN_HZ;
    localparam int BAND_HI_HZ = 54;
    localparam int BAND_LO_HZ = 23;
    localparam int BAND_WIDE_LO_HZ = 12;
    localparam int PERIOD_W = 16;
    localparam int PERIOD_MIN = MAIN_HZ / BAND_HI_HZ;
    localparam int PERIOD_MAX = MAIN_HZ / BAND_LO_HZ;
    localparam int PERIOD_MAX_WIDE = MAIN_HZ / BAND_WIDE_LO_HZ;
    localparam int TONE_DIV_LOW = 560;
    localparam int TONE_DIV_MID = 420;
    localparam int TONE_DIV_HIGH = 336;
    localparam int TONE_W = 9;
    localparam int TONE_COUNT = 3;
    localparam int SEQ_PERIODS_PER_TONE = 32;
    localparam int PULSE_LIMIT_NS = 200_000;
    localparam int PULSE_LIMIT_CYC = (PULSE_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {BAND_NORMAL, BAND_WIDE, BAND_DC} rtr_band_t;

    typedef struct packed {
        logic ringIn;
        logic bandFloat;
        logic bandLevel;
        logic pulseFloat;
        logic supplyOn;
        logic supplyHold;
        logic seqOsc;
    } rtr_pins_t;

    typedef struct packed {
        logic toneP;
        logic toneN;
        logic loadSwitch;
    } rtr_out_t;

    // half period of the selected tone in main clock ticks
    function automatic logic [TONE_W-1:0] toneHalf(input logic [1:0] idx);
        logic [TONE_W-1:0] h;
        h = TONE_W'(TONE_DIV_LOW / 2);
        if (idx == 2'h1) begin
            h = TONE_W'(TONE_DIV_MID / 2);
        end else if (idx == 2'h2) begin
            h = TONE_W'(TONE_DIV_HIGH / 2);
        end
        return h;
    endfunction
endpackage
`default_nettype wire

// File: rtr_period_meter.sv
// ringing period meter and band check
`default_nettype none
`timescale 1ns/1ps
module rtr_period_meter import rtr_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic ringLvl,
    input wire logic mainTick,
    input wire rtr_band_t bandMode,
    output var logic inBand
);
    localparam logic [PERIOD_W-1:0] P_MIN = PERIOD_W'(PERIOD_MIN);
    localparam logic [PERIOD_W-1:0] P_MAX = PERIOD_W'(PERIOD_MAX);
    localparam logic [PERIOD_W-1:0] P_MAXW = PERIOD_W'(PERIOD_MAX_WIDE);

    logic prevLvl_r, prevLvl_nxt;
    logic [PERIOD_W-1:0] cnt_r, cnt_nxt;
    logic inBand_r, inBand_nxt;
    logic [PERIOD_W-1:0] limMax;

    always_comb begin
        limMax = (bandMode == BAND_WIDE) ? P_MAXW : P_MAX;
        prevLvl_nxt = ringLvl;
        cnt_nxt = cnt_r;
        inBand_nxt = inBand_r;
        if (ringLvl && !prevLvl_r) begin
            // full input cycle ends: judge the period
            inBand_nxt = (cnt_r >= P_MIN) && (cnt_r <= limMax);
            cnt_nxt = '0;
        end else if (mainTick && cnt_r <= limMax) begin
            cnt_nxt = cnt_r + 1'b1;
        end
        if (cnt_r > limMax) begin
            inBand_nxt = 1'b0;
        end
        if (bandMode == BAND_DC) begin
            inBand_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prevLvl_r <= 1'b0;
            cnt_r <= '0;
            inBand_r <= 1'b0;
        end else begin
            prevLvl_r <= prevLvl_nxt;
            cnt_r <= cnt_nxt;
            inBand_r <= inBand_nxt;
        end
    end

    assign inBand = inBand_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_dc_accept: assert property (bandMode == BAND_DC |=> inBand)
        else $error("dc mode did not accept");
    a_short_reject: assert property (ringLvl && !prevLvl_r && cnt_r < P_MIN
        && bandMode != BAND_DC |=> !inBand)
        else $error("too short ringing period accepted");
    a_long_reject: assert property (cnt_r > limMax && bandMode != BAND_DC
        |=> !inBand)
        else $error("too long ringing period accepted");
endmodule // rtr_period_meter
`default_nettype wire

// File: rtr_ringer.sv
// three-tone ringer sequencer core
`default_nettype none
`timescale 1ns/1ps
module rtr_ringer import rtr_pkg::*; #(
    parameter int PULSE_LIMIT_CYCLES = PULSE_LIMIT_CYC,
    parameter int MAIN_DIVIDE = MAIN_DIV
) (
    input wire logic clk,
    input wire logic reset,
    input wire rtr_pins_t pinsIn,
    output var rtr_out_t pinsOut,
    output var logic toneActive
);
    localparam int PL_W = 16;
    localparam int MD_W = 10;

    // elaboration checks on parameter ranges
    if (PULSE_LIMIT_CYCLES < 1 || PULSE_LIMIT_CYCLES >= (1 << PL_W)) begin : g_bad_pl
        $error("pulse limit count out of range");
    end
    if (MAIN_DIVIDE < 1 || MAIN_DIVIDE >= (1 << MD_W)) begin : g_bad_md
        $error("main divide out of range");
    end

    localparam logic [PL_W-1:0] PL_LIM = PL_W'(PULSE_LIMIT_CYCLES);
    localparam logic [MD_W-1:0] MD_LAST = MD_W'(MAIN_DIVIDE - 1);
    localparam logic [4:0] SEQ_LAST = 5'(SEQ_PERIODS_PER_TONE - 1);
    localparam logic [1:0] TONE_LAST = 2'(TONE_COUNT - 1);

    // pin synchroniser, three stages, change taken when two and three agree
    rtr_pins_t s1_r, s2_r, s3_r, filt_r;
    rtr_pins_t s1_nxt, s2_nxt, s3_nxt, filt_nxt;

    always_comb begin
        s1_nxt = pinsIn;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        filt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            filt_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            filt_r <= filt_nxt;
        end
    end

    // band mode from the three-way option
    rtr_band_t bandMode;

    always_comb begin
        if (filt_r.bandFloat) begin
            bandMode = BAND_NORMAL;
        end else if (filt_r.bandLevel) begin
            bandMode = BAND_DC;
        end else begin
            bandMode = BAND_WIDE;
        end
    end

    // main clock tick generation
    logic [MD_W-1:0] mainCnt_r, mainCnt_nxt;
    logic mainTick;

    always_comb begin
        mainTick = (mainCnt_r == MD_LAST);
        mainCnt_nxt = mainTick ? '0 : mainCnt_r + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mainCnt_r <= '0;
        end else begin
            mainCnt_r <= mainCnt_nxt;
        end
    end

    logic inBand;

    rtr_period_meter u_meter (
        .clk(clk),
        .reset(reset),
        .ringLvl(filt_r.ringIn),
        .mainTick(mainTick),
        .bandMode(bandMode),
        .inBand(inBand)
    );

    // supply level hysteresis and activation
    logic supplyOk_r, supplyOk_nxt;
    logic active_r, active_nxt;
    logic startTones;

    always_comb begin
        supplyOk_nxt = supplyOk_r;
        if (filt_r.supplyOn) begin
            supplyOk_nxt = 1'b1;
        end else if (!filt_r.supplyHold) begin
            supplyOk_nxt = 1'b0;
        end
        active_nxt = inBand && supplyOk_r;
        startTones = active_nxt && !active_r;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            supplyOk_r <= 1'b0;
            active_r <= 1'b0;
        end else begin
            supplyOk_r <= supplyOk_nxt;
            active_r <= active_nxt;
        end
    end

    // tone sequencer on the sequence oscillator
    logic seqPrev_r, seqPrev_nxt;
    logic [4:0] seqCnt_r, seqCnt_nxt;
    logic [1:0] toneIdx_r, toneIdx_nxt;
    logic seqEdge;

    always_comb begin
        seqPrev_nxt = filt_r.seqOsc;
        seqEdge = filt_r.seqOsc && !seqPrev_r;
        seqCnt_nxt = seqCnt_r;
        toneIdx_nxt = toneIdx_r;
        if (startTones) begin
            seqCnt_nxt = '0;
            toneIdx_nxt = '0;
        end else if (active_r && seqEdge) begin
            if (seqCnt_r == SEQ_LAST) begin
                seqCnt_nxt = '0;
                toneIdx_nxt = (toneIdx_r == TONE_LAST) ? 2'h0 : toneIdx_r + 2'h1;
            end else begin
                seqCnt_nxt = seqCnt_r + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            seqPrev_r <= 1'b0;
            seqCnt_r <= '0;
            toneIdx_r <= '0;
        end else begin
            seqPrev_r <= seqPrev_nxt;
            seqCnt_r <= seqCnt_nxt;
            toneIdx_r <= toneIdx_nxt;
        end
    end

    // tone divider and pulse limiter
    logic [TONE_W-1:0] toneCnt_r, toneCnt_nxt;
    logic phase_r, phase_nxt;
    logic [PL_W-1:0] pulseCnt_r, pulseCnt_nxt;
    logic [TONE_W-1:0] half;
    logic trunc;

    always_comb begin
        half = toneHalf(toneIdx_r);
        toneCnt_nxt = toneCnt_r;
        phase_nxt = phase_r;
        pulseCnt_nxt = pulseCnt_r;
        if (startTones) begin
            toneCnt_nxt = '0;
            phase_nxt = 1'b1;
            pulseCnt_nxt = '0;
        end else if (active_r) begin
            if (pulseCnt_r != PL_LIM) begin
                pulseCnt_nxt = pulseCnt_r + 1'b1;
            end
            if (mainTick) begin
                if (toneCnt_r >= half - 1'b1) begin
                    toneCnt_nxt = '0;
                    phase_nxt = !phase_r;
                    pulseCnt_nxt = '0;
                end else begin
                    toneCnt_nxt = toneCnt_r + 1'b1;
                end
            end
        end
        trunc = filt_r.pulseFloat && (pulseCnt_r == PL_LIM);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            toneCnt_r <= '0;
            phase_r <= 1'b1;
            pulseCnt_r <= '0;
        end else begin
            toneCnt_r <= toneCnt_nxt;
            phase_r <= phase_nxt;
            pulseCnt_r <= pulseCnt_nxt;
        end
    end

    // registered pin outputs
    rtr_out_t out_r, out_nxt;

    always_comb begin
        out_nxt.toneP = active_r && phase_r && !trunc;
        out_nxt.toneN = active_r && !phase_r && !trunc;
        out_nxt.loadSwitch = !active_r;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            out_r <= '{toneP: 1'b0, toneN: 1'b0, loadSwitch: 1'b1};
        end else begin
            out_r <= out_nxt;
        end
    end

    assign pinsOut = out_r;
    assign toneActive = active_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_start_needs: assert property ($rose(active_r) |-> $past(inBand && supplyOk_r))
        else $error("tones started without both conditions");
    a_stop_band: assert property (active_r && !inBand |=> !active_r)
        else $error("tones kept running out of band");
    a_supply_off: assert property (!filt_r.supplyOn && !filt_r.supplyHold
        |=> ##1 !active_r)
        else $error("tones kept running below turn-off level");
    a_first_tone: assert property ($rose(active_r) |-> toneIdx_r == 2'h0
        && seqCnt_r == 5'h00)
        else $error("sequence did not restart at lowest tone");
    a_tone_step: assert property (active_r && seqEdge && seqCnt_r == SEQ_LAST
        && toneIdx_r == 2'h2 && !startTones |=> toneIdx_r == 2'h0)
        else $error("tone sequence did not wrap after third tone");
    a_opp_phase: assert property (!(pinsOut.toneP && pinsOut.toneN))
        else $error("tone outputs driven in same phase");
    a_phase_flip: assert property (active_r && mainTick && !startTones
        && toneCnt_r == toneHalf(toneIdx_r) - 1'b1 |=> phase_r != $past(phase_r))
        else $error("tone half period wrong");
    a_pulse_limit: assert property (filt_r.pulseFloat && pulseCnt_r == PL_LIM
        && !startTones |=> !pinsOut.toneP && !pinsOut.toneN)
        else $error("pulse not truncated");
    a_load_switch: assert property (active_r |=> !pinsOut.loadSwitch)
        else $error("load switch not released while active");
    a_load_idle: assert property (!active_r |=> pinsOut.loadSwitch
        && !pinsOut.toneP && !pinsOut.toneN)
        else $error("idle outputs wrong");
endmodule // rtr_ringer
`default_nettype wire

// File: rtr_line_model.sv
// ringing line source and sound transducer monitor
`timescale 1ns/1ps
`default_nettype none
module rtr_line_model (
    input wire logic clk,
    input wire logic ringEn,
    input wire logic signed [31:0] ringPeriod,
    output var logic ringIn,
    input wire logic toneP,
    input wire logic toneN,
    output var int lastPeriod,
    output var int highWidth,
    output var int overlaps
);
    int phase = 0;
    int sinceRise = 0;
    int hiCnt = 0;
    logic prevP = 1'h0;
    initial begin
        ringIn = 1'h0;
        lastPeriod = 0;
        highWidth = 0;
        overlaps = 0;
    end
    // line idle low between rings; transducer sees edge spacing and pulse width
    always @(posedge clk) begin
        phase <= (ringEn && phase < ringPeriod - 1) ? phase + 1 : 0;
        ringIn <= ringEn && (phase < ringPeriod / 2);
        prevP <= toneP;
        sinceRise <= (toneP && !prevP) ? 1 : sinceRise + 1;
        if (toneP && !prevP) lastPeriod <= sinceRise;
        hiCnt <= toneP ? hiCnt + 1 : 0;
        if (!toneP && prevP) highWidth <= hiCnt;
        if (toneP && toneN) overlaps <= overlaps + 1;
    end
endmodule // rtr_line_model
`default_nettype wire

// File: tb.sv
// self-checking bench for the three-tone ringer sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rtr_pkg::*;
    localparam int MDIV = 1;
    localparam int PLIM = 20;
    logic clk = 1'h0;
    logic reset = 1'h1;
    rtr_pins_t pins = '0;
    rtr_pins_t pinsDrv;
    rtr_out_t pinsOut;
    logic toneActive, ringLine;
    logic seqLine = 1'h0;
    logic ringEn = 1'h0;
    int ringPeriod = 20000;
    int lastPeriod, highWidth, overlaps;
    int mismatches = 0;
    int compares = 0;
    int seqCnt = 0;
    int n, bad;
    assign pinsDrv = {ringLine, pins[5:1], seqLine};
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        seqCnt <= (seqCnt == 49) ? 0 : seqCnt + 1;
        if (seqCnt == 49) seqLine <= ~seqLine;
    end
    rtr_ringer #(.PULSE_LIMIT_CYCLES(PLIM), .MAIN_DIVIDE(MDIV)) dut_u (
        .clk(clk), .reset(reset), .pinsIn(pinsDrv), .pinsOut(pinsOut),
        .toneActive(toneActive));
    rtr_line_model line_u (.clk(clk), .ringEn(ringEn), .ringPeriod(ringPeriod),
        .ringIn(ringLine), .toneP(pinsOut.toneP), .toneN(pinsOut.toneN),
        .lastPeriod(lastPeriod), .highWidth(highWidth), .overlaps(overlaps));
    function automatic int expPeriod(input int k);
        if (k % 3 == 0) return TONE_DIV_LOW * MDIV;
        if (k % 3 == 1) return TONE_DIV_MID * MDIV;
        return TONE_DIV_HIGH * MDIV;
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // bounded wait for toneActive to reach lvl
    task automatic wait_act(input logic lvl, input int bound);
        n = 0;
        while (toneActive !== lvl && n < bound) begin
            @(negedge clk);
            n++;
        end
        if (toneActive !== lvl) begin
            mismatches++;
            $display("[FAIL] toneActive wait expected %0d seen %0d", lvl, toneActive);
            print_verdict();
        end
    endtask
    initial begin
        n = $urandom(32'hB545);
        repeat (16) @(posedge clk);
        reset <= 1'h0;
        @(negedge clk);
        check("reset toneP", pinsOut.toneP, 0);
        check("reset load", pinsOut.loadSwitch, 1);
        @(posedge clk);
        pins.bandLevel <= 1'h1;
        repeat (60) @(negedge clk);
        check("no supply active", toneActive, 0);
        check("no supply load", pinsOut.loadSwitch, 1);
        @(posedge clk);
        pins.supplyOn <= 1'h1;
        pins.supplyHold <= 1'h1;
        wait_act(1, 20);
        check("dc start", toneActive, 1);
        repeat (4) @(negedge clk);
        check("active load", pinsOut.loadSwitch, 0);
        bad = 0;
        repeat (1500) begin
            @(negedge clk);
            if (pinsOut.toneN !== ~pinsOut.toneP) bad++;
        end
        check("opposite phase", bad, 0);
        repeat (96) @(negedge clk);
        check("full width", highWidth, TONE_DIV_LOW * MDIV / 2);
        for (int k = 0; k < 4; k++) begin
            if (k > 0) repeat (SEQ_PERIODS_PER_TONE * 100) @(negedge clk);
            check("tone period", lastPeriod, expPeriod(k));
        end
        $display("test sequence done");
        @(posedge clk);
        pins.pulseFloat <= 1'h1;
        repeat (600 + $urandom_range(0, 200)) @(negedge clk);
        check("limited width", highWidth, PLIM);
        check("overlap", overlaps, 0);
        repeat (2500) @(negedge clk);
        @(posedge clk);
        pins.supplyOn <= 1'h0;
        repeat (50) @(negedge clk);
        check("hold active", toneActive, 1);
        @(posedge clk);
        pins.supplyHold <= 1'h0;
        wait_act(0, 20);
        repeat (3) @(negedge clk);
        check("stop load", pinsOut.loadSwitch, 1);
        check("stop toneP", pinsOut.toneP, 0);
        @(posedge clk);
        pins.supplyHold <= 1'h1;
        pins.pulseFloat <= 1'h0;
        repeat (50) @(negedge clk);
        check("no restart", toneActive, 0);
        @(posedge clk);
        pins.supplyOn <= 1'h1;
        wait_act(1, 20);
        repeat (1200) @(negedge clk);
        check("restart tone", lastPeriod, TONE_DIV_LOW * MDIV);
        $display("test supply done");
        @(posedge clk);
        reset <= 1'h1;
        pins.bandLevel <= 1'h0;
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        ringEn <= 1'h1;
        // about 17 Hz in main ticks: wide band takes it, normal band refuses it
        ringPeriod <= 26000 + $urandom_range(0, 1000);
        wait_act(1, 63100);
        check("wide band", toneActive, 1);
        @(posedge clk);
        pins.bandFloat <= 1'h1;
        wait_act(0, 42000);
        check("low reject", toneActive, 0);
        @(posedge clk);
        ringPeriod <= 8600 + $urandom_range(0, 2400);
        wait_act(1, 33100);
        check("normal band", toneActive, 1);
        @(posedge clk);
        ringPeriod <= 4000 + $urandom_range(0, 3500);
        wait_act(0, 22800);
        check("high reject", toneActive, 0);
        $display("test band done");
        print_verdict();
    end
endmodule // tb
`default_nettype wire
